// ===== common/ddr_xbank_pkg.sv
package ddr_xbank_pkg;
	localparam int BANKS = 4;
	localparam int BANK_W = 2;
	localparam int DATA_W = 16;
	localparam int TMR_W = 4;
	localparam int CLK_NS = 25;
	localparam int PRECHARGE_PERIOD_NS = 20;
	localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 20;
	localparam int SELF_REFRESH_EXIT_DELAY_NS = 75;
	localparam int REFRESH_NS = 75;
	localparam int PRE_CK = (PRECHARGE_PERIOD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RCD_CK = (ACTIVATE_TO_COLUMN_DELAY_NS + CLK_NS - 1)
		/ CLK_NS;
	localparam int SRX_CK = (SELF_REFRESH_EXIT_DELAY_NS + CLK_NS - 1)
		/ CLK_NS;
	localparam int RFC_CK = (REFRESH_NS + CLK_NS - 1) / CLK_NS;
	localparam int MODE_SET_CK = 2;
	localparam int BURST_LENGTH = 4;
	localparam int BEATS = BURST_LENGTH / 2;
	localparam int READ_LATENCY = 3;
	localparam int WRITE_TO_READ_DELAY_CK = 1;
	localparam int RD_SPAN = READ_LATENCY + BEATS;
	localparam int WR_SPAN = 1 + BEATS;
	localparam int WR_TO_RD_GAP = 1 + BEATS + WRITE_TO_READ_DELAY_CK;
	localparam int WR_TO_WR_GAP = BEATS;
	localparam int RD_TO_RD_GAP = BEATS;
	localparam int RD_TO_WR_GAP = READ_LATENCY + BEATS;
	localparam int AP_TO_ROW_GAP = 1;
	localparam int INIT_WAIT = SRX_CK + 2;

	// command pin encodings as {rasN, casN, weN}
	localparam logic [2:0] ENC_NOP = 3'h7;
	localparam logic [2:0] ENC_ACTIVE = 3'h3;
	localparam logic [2:0] ENC_READ = 3'h5;
	localparam logic [2:0] ENC_WRITE = 3'h4;
	localparam logic [2:0] ENC_PRECHARGE = 3'h2;
	localparam logic [2:0] ENC_BURST_STOP = 3'h6;
	localparam logic [2:0] ENC_REFRESH = 3'h1;
	localparam logic [2:0] ENC_MODE_SET = 3'h0;

	typedef logic [TMR_W-1:0] tmr_t;
	typedef enum logic [3:0] {CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
		CMD_PRECHARGE, CMD_BURST_STOP, CMD_REFRESH, CMD_MODE_SET} cmd_e;
	typedef enum logic [2:0] {B_IDLE, B_ACTIVATING, B_ACTIVE, B_READ,
		B_WRITE, B_READ_AP, B_WRITE_AP, B_PRECHARGING} bank_e;

	// a bank loaded with stay(k) leaves its state k cycles after the command, or 2 cycles after it when k is 1
	function automatic tmr_t stay(input int k);
		return (k > 1) ? TMR_W'(k - 2) : TMR_W'(0);
	endfunction

	// a gap loaded with gap(k) allows the next command k cycles later
	function automatic tmr_t gap(input int k);
		return TMR_W'(k - 1);
	endfunction

	function automatic bank_e settle(input bank_e s);
		case (s)
			B_ACTIVATING, B_READ, B_WRITE: return B_ACTIVE;
			B_READ_AP, B_WRITE_AP, B_PRECHARGING: return B_IDLE;
			default: return s;
		endcase
	endfunction

	function automatic logic isOpen(input bank_e s);
		return s == B_ACTIVE || s == B_READ || s == B_WRITE;
	endfunction
endpackage

// ===== common/ddr_cmd_if.sv
`timescale 1ns/1ps
interface ddr_cmd_if
	import ddr_xbank_pkg::*;
	();
	logic cke;
	logic csN;
	logic rasN;
	logic casN;
	logic weN;
	logic autoPrecharge;
	logic [BANK_W-1:0] bank;
	logic [DATA_W-1:0] dqCtl;
	logic dqCtlOe;
	logic writeDataMask;
	logic [DATA_W-1:0] dqDev;
	logic dqDevOe;

	modport ctl (
		output cke,
		output csN,
		output rasN,
		output casN,
		output weN,
		output autoPrecharge,
		output bank,
		output dqCtl,
		output dqCtlOe,
		output writeDataMask,
		input dqDev,
		input dqDevOe
	);

	modport dev (
		input cke,
		input csN,
		input rasN,
		input casN,
		input weN,
		input autoPrecharge,
		input bank,
		input dqCtl,
		input dqCtlOe,
		input writeDataMask,
		output dqDev,
		output dqDevOe
	);
endinterface

// ===== rtl/ddr_bank_device.sv
`timescale 1ns/1ps
module ddr_bank_device (
	input wire logic clk,
	input wire logic rst,
	ddr_cmd_if.dev bus,
	input wire logic [ddr_xbank_pkg::DATA_W-1:0] readWord,
	output logic [ddr_xbank_pkg::DATA_W-1:0] writeWord,
	output logic writeStrobe,
	output logic [ddr_xbank_pkg::BANKS-1:0] bankIdle,
	output logic cmdIllegal
);
	import ddr_xbank_pkg::*;

	bank_e st [BANKS];
	bank_e next_st [BANKS];
	tmr_t tmr [BANKS];
	tmr_t next_tmr [BANKS];
	logic ckePrev;
	tmr_t srWait, next_srWait;
	tmr_t glob, next_glob;
	tmr_t rdCnt, next_rdCnt;
	logic [BANK_W-1:0] lastRd, next_lastRd;
	logic next_illegal;
	logic [BANKS-1:0] next_bankIdle;
	logic live;
	cmd_e cmd;

	////////////////////////////////////////////////////////////////////
	// command decode
	always_comb begin
		live = bus.cke && ckePrev && srWait == '0 && glob == '0; // R2
		cmd = CMD_NOP; // R1
		if (live && !bus.csN) begin
			case ({bus.rasN, bus.casN, bus.weN})
				ENC_ACTIVE: cmd = CMD_ACTIVE;
				ENC_READ: cmd = CMD_READ;
				ENC_WRITE: cmd = CMD_WRITE;
				ENC_PRECHARGE: cmd = CMD_PRECHARGE;
				ENC_BURST_STOP: cmd = CMD_BURST_STOP;
				ENC_REFRESH: cmd = CMD_REFRESH;
				ENC_MODE_SET: cmd = CMD_MODE_SET;
				default: cmd = CMD_NOP;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// bank states and cross-bank checks
	always_comb begin
		logic allIdle;
		logic otherRd;
		logic [BANK_W-1:0] bk;
		allIdle = 1'b1;
		otherRd = 1'b0;
		bk = bus.bank;
		next_st = st;
		next_tmr = tmr;
		next_illegal = 1'b0;
		next_lastRd = lastRd;
		next_glob = (glob != '0) ? glob - 1'b1 : glob;
		next_rdCnt = (rdCnt != '0) ? rdCnt - 1'b1 : rdCnt;
		next_srWait = (srWait != '0) ? srWait - 1'b1 : srWait;
		if (bus.cke && !ckePrev)
			next_srWait = TMR_W'(SRX_CK); // R2
		for (int b = 0; b < BANKS; b++) begin
			if (st[b] != B_IDLE)
				allIdle = 1'b0;
			if (st[b] == B_READ && BANK_W'(b) != bk)
				otherRd = 1'b1;
			if (tmr[b] != '0)
				next_tmr[b] = tmr[b] - 1'b1;
			else
				next_st[b] = settle(st[b]); // R8 R17
		end
		case (cmd)
			CMD_ACTIVE: begin
				if (st[bk] == B_IDLE) begin // R4
					next_st[bk] = B_ACTIVATING;
					next_tmr[bk] = stay(RCD_CK);
				end else
					next_illegal = 1'b1; // R17
			end
			CMD_READ: begin
				if (isOpen(st[bk])) begin // R12
					next_st[bk] = bus.autoPrecharge ? B_READ_AP : B_READ;
					next_tmr[bk] = bus.autoPrecharge ?
						stay(RD_SPAN + PRE_CK) : stay(RD_SPAN);
					next_rdCnt = TMR_W'(RD_SPAN - 1);
					next_lastRd = bk;
				end else
					next_illegal = 1'b1;
			end
			CMD_WRITE: begin
				// a write may not collide with read data still due
				if (isOpen(st[bk]) && !otherRd && rdCnt == '0) begin
					next_st[bk] = bus.autoPrecharge ? B_WRITE_AP : B_WRITE;
					next_tmr[bk] = bus.autoPrecharge ?
						stay(WR_SPAN + PRE_CK) : stay(WR_SPAN);
				end else
					next_illegal = 1'b1;
			end
			CMD_PRECHARGE: begin
				if (isOpen(st[bk])) begin // R4
					next_st[bk] = B_PRECHARGING;
					next_tmr[bk] = stay(PRE_CK);
					if (st[bk] == B_READ && lastRd == bk)
						next_rdCnt = '0;
				end else if (st[bk] != B_IDLE)
					next_illegal = 1'b1; // R17
			end
			CMD_BURST_STOP: begin
				if (st[lastRd] == B_READ) begin // R10
					next_st[lastRd] = B_ACTIVE;
					next_tmr[lastRd] = '0;
					next_rdCnt = '0;
				end
			end
			CMD_REFRESH, CMD_MODE_SET: begin
				if (allIdle)
					next_glob = (cmd == CMD_REFRESH) ?
						gap(RFC_CK) : gap(MODE_SET_CK);
				else
					next_illegal = 1'b1;
			end
			default: ;
		endcase
		// idle flags follow the state after this cycle's command
		for (int b = 0; b < BANKS; b++)
			next_bankIdle[b] = next_st[b] == B_IDLE; // R8
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int b = 0; b < BANKS; b++) begin
				st[b] <= B_IDLE;
				tmr[b] <= '0;
			end
			ckePrev <= 1'b0;
			srWait <= '0;
			glob <= '0;
			rdCnt <= '0;
			lastRd <= '0;
			cmdIllegal <= 1'b0;
			bankIdle <= '1;
		end else begin
			st <= next_st;
			tmr <= next_tmr;
			ckePrev <= bus.cke;
			srWait <= next_srWait;
			glob <= next_glob;
			rdCnt <= next_rdCnt;
			lastRd <= next_lastRd;
			cmdIllegal <= next_illegal;
			bankIdle <= next_bankIdle;
		end
	end

	////////////////////////////////////////////////////////////////////
	// data bus: read beats after the latency, masked write capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus.dqDevOe <= 1'b0;
			bus.dqDev <= '0;
			writeWord <= '0;
			writeStrobe <= 1'b0;
		end else begin
			bus.dqDevOe <= rdCnt >= TMR_W'(2)
				&& rdCnt <= TMR_W'(BEATS + 1);
			bus.dqDev <= readWord;
			writeStrobe <= bus.dqCtlOe && !bus.writeDataMask;
			if (bus.dqCtlOe && !bus.writeDataMask)
				writeWord <= bus.dqCtl;
		end
	end
endmodule

// ===== rtl/ddr_xbank_ctl.sv
`timescale 1ns/1ps
// Function
// R1: deselect or NOP starts nothing new
// R2: commands only with clock enable steady, exit done
// R3: judge bank m command against other banks
// R4: activating, active, precharging bank allows all row/column
// R5: during plain read, no write elsewhere
// R6: during plain write, read elsewhere needs mask
// R7: auto precharge bursts allow all, after delays
// R8: idle and row active defined by periods
// R9: refresh and mode set need all banks idle
// R10: burst stop only to current burst bank
// R11: avoid unlisted state and command pairs
// R12: concurrent auto precharge, no transfer interruption
// R13: read and write data never collide
// R14: write after read only when output done
// R15: after write: read, write, row gaps
// R16: after read: read, write, row gaps
// R17: auto precharge bank unavailable until period ends
// R18: per-bank state and timers gate issue
module ddr_xbank_ctl (
	input wire logic clk,
	input wire logic rst,
	ddr_cmd_if.ctl bus,
	input wire logic reqValid,
	input wire ddr_xbank_pkg::cmd_e reqCmd,
	input wire logic [ddr_xbank_pkg::BANK_W-1:0] reqBank,
	input wire logic reqAutoPrecharge,
	input wire logic [ddr_xbank_pkg::DATA_W-1:0] reqWord,
	output logic reqTaken,
	output logic reqRejected,
	output logic [ddr_xbank_pkg::DATA_W-1:0] readWord,
	output logic readValid
);
	import ddr_xbank_pkg::*;

	bank_e st [BANKS];
	bank_e next_st [BANKS];
	tmr_t tmr [BANKS];
	tmr_t next_tmr [BANKS];
	tmr_t rdGap, next_rdGap;
	tmr_t wrGap, next_wrGap;
	tmr_t rowGap, next_rowGap;
	tmr_t glob, next_glob;
	tmr_t initWait, next_initWait;
	tmr_t wrLeft, next_wrLeft;
	logic [BANK_W-1:0] lastRd, next_lastRd;
	logic [DATA_W-1:0] word, next_word;
	logic [2:0] next_enc;
	logic next_csN;
	logic next_ap;
	logic [BANK_W-1:0] next_bank;
	logic next_taken;
	logic next_rejected;

	////////////////////////////////////////////////////////////////////
	// issue decision
	always_comb begin
		logic allIdle;
		logic otherRd;
		logic fits;
		logic ok;
		logic go;
		logic [BANK_W-1:0] bk;
		bank_e s;
		allIdle = 1'b1;
		otherRd = 1'b0;
		fits = 1'b1;
		ok = 1'b0;
		bk = reqBank;
		s = st[reqBank];
		next_st = st;
		next_tmr = tmr;
		next_rdGap = (rdGap != '0) ? rdGap - 1'b1 : rdGap;
		next_wrGap = (wrGap != '0) ? wrGap - 1'b1 : wrGap;
		next_rowGap = (rowGap != '0) ? rowGap - 1'b1 : rowGap;
		next_glob = (glob != '0) ? glob - 1'b1 : glob;
		next_initWait = (initWait != '0) ? initWait - 1'b1 : initWait;
		next_wrLeft = (wrLeft != '0) ? wrLeft - 1'b1 : wrLeft;
		next_lastRd = lastRd;
		next_word = word;
		next_enc = ENC_NOP;
		next_csN = 1'b1; // R1
		next_ap = 1'b0;
		next_bank = '0;
		next_taken = 1'b0;
		next_rejected = 1'b0;
		for (int b = 0; b < BANKS; b++) begin
			if (st[b] != B_IDLE)
				allIdle = 1'b0;
			if (st[b] == B_READ && BANK_W'(b) != reqBank)
				otherRd = 1'b1;
			if (tmr[b] != '0)
				next_tmr[b] = tmr[b] - 1'b1;
			else
				next_st[b] = settle(st[b]); // R8 R18
		end
		case (reqCmd)
			CMD_ACTIVE: begin
				fits = s == B_IDLE; // R3
				ok = fits && rowGap == '0; // R15 R16
			end
			CMD_READ: begin
				fits = isOpen(s); // R3 R6
				ok = fits && rdGap == '0; // R15 R16
			end
			CMD_WRITE: begin
				fits = isOpen(s);
				ok = fits && wrGap == '0 && !otherRd; // R5 R13 R14
			end
			CMD_PRECHARGE: begin
				fits = isOpen(s) || s == B_IDLE;
				ok = fits && rowGap == '0; // R4 R7
			end
			CMD_BURST_STOP: begin
				bk = lastRd; // R10
				fits = st[lastRd] == B_READ;
				ok = fits;
			end
			CMD_REFRESH, CMD_MODE_SET: begin
				ok = allIdle && wrLeft == '0; // R9
			end
			default: ok = 1'b1;
		endcase
		go = reqValid && !reqTaken && initWait == '0 && glob == '0
			&& ok; // R2 R18
		// a command that the bank can never take in a settled state
		if (reqValid && !reqTaken && !fits
			&& (s == B_IDLE || isOpen(s))) begin
			next_rejected = 1'b1; // R11
			next_taken = 1'b1;
		end
		if (go) begin
			next_taken = 1'b1;
			next_bank = bk;
			next_csN = reqCmd == CMD_NOP;
			case (reqCmd)
				CMD_ACTIVE: begin
					next_enc = ENC_ACTIVE;
					next_st[bk] = B_ACTIVATING;
					next_tmr[bk] = stay(RCD_CK);
				end
				CMD_READ: begin
					next_enc = ENC_READ;
					next_ap = reqAutoPrecharge;
					next_st[bk] = reqAutoPrecharge ? B_READ_AP : B_READ;
					next_tmr[bk] = reqAutoPrecharge ?
						stay(RD_SPAN + PRE_CK) : stay(RD_SPAN); // R17
					next_lastRd = bk;
					next_rdGap = gap(RD_TO_RD_GAP); // R16
					next_wrGap = gap(RD_TO_WR_GAP); // R14 R16
					next_rowGap = gap(AP_TO_ROW_GAP); // R16
				end
				CMD_WRITE: begin
					next_enc = ENC_WRITE;
					next_ap = reqAutoPrecharge;
					next_st[bk] = reqAutoPrecharge ? B_WRITE_AP : B_WRITE;
					next_tmr[bk] = reqAutoPrecharge ?
						stay(WR_SPAN + PRE_CK) : stay(WR_SPAN); // R17
					next_word = reqWord;
					next_wrLeft = TMR_W'(BEATS);
					next_rdGap = gap(WR_TO_RD_GAP); // R15
					next_wrGap = gap(WR_TO_WR_GAP); // R15
					next_rowGap = gap(AP_TO_ROW_GAP); // R15
				end
				CMD_PRECHARGE: begin
					next_enc = ENC_PRECHARGE;
					if (s != B_IDLE) begin
						next_st[bk] = B_PRECHARGING;
						next_tmr[bk] = stay(PRE_CK);
					end
				end
				CMD_BURST_STOP: begin
					next_enc = ENC_BURST_STOP;
					next_st[bk] = B_ACTIVE; // R10
					next_tmr[bk] = '0;
					next_wrGap = '0;
				end
				CMD_REFRESH: begin
					next_enc = ENC_REFRESH;
					next_glob = gap(RFC_CK);
				end
				CMD_MODE_SET: begin
					next_enc = ENC_MODE_SET;
					next_glob = gap(MODE_SET_CK);
				end
				default: next_enc = ENC_NOP;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int b = 0; b < BANKS; b++) begin
				st[b] <= B_IDLE;
				tmr[b] <= '0;
			end
			rdGap <= '0;
			wrGap <= '0;
			rowGap <= '0;
			glob <= '0;
			initWait <= TMR_W'(INIT_WAIT);
			wrLeft <= '0;
			lastRd <= '0;
			word <= '0;
			reqTaken <= 1'b0;
			reqRejected <= 1'b0;
		end else begin
			st <= next_st;
			tmr <= next_tmr;
			rdGap <= next_rdGap;
			wrGap <= next_wrGap;
			rowGap <= next_rowGap;
			glob <= next_glob;
			initWait <= next_initWait;
			wrLeft <= next_wrLeft;
			lastRd <= next_lastRd;
			word <= next_word;
			reqTaken <= next_taken;
			reqRejected <= next_rejected;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pins and data bus
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus.cke <= 1'b0;
			bus.csN <= 1'b1;
			bus.rasN <= 1'b1;
			bus.casN <= 1'b1;
			bus.weN <= 1'b1;
			bus.autoPrecharge <= 1'b0;
			bus.bank <= '0;
			bus.dqCtl <= '0;
			bus.dqCtlOe <= 1'b0;
			bus.writeDataMask <= 1'b1;
			readWord <= '0;
			readValid <= 1'b0;
		end else begin
			bus.cke <= 1'b1; // R2
			bus.csN <= next_csN;
			{bus.rasN, bus.casN, bus.weN} <= next_enc;
			bus.autoPrecharge <= next_ap;
			bus.bank <= next_bank;
			bus.dqCtl <= word;
			bus.dqCtlOe <= wrLeft != '0; // R13
			bus.writeDataMask <= wrLeft == '0; // R6
			readValid <= bus.dqDevOe;
			if (bus.dqDevOe)
				readWord <= bus.dqDev;
		end
	end
endmodule

// ===== tb/ddr_xbank_properties.sv
`timescale 1ns/1ps
module ddr_xbank_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic cke,
	input wire logic csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic autoPrecharge,
	input wire logic [ddr_xbank_pkg::BANK_W-1:0] bank,
	input wire logic [ddr_xbank_pkg::DATA_W-1:0] dqCtl,
	input wire logic dqCtlOe,
	input wire logic writeDataMask,
	input wire logic [ddr_xbank_pkg::DATA_W-1:0] dqDev,
	input wire logic dqDevOe
);
	import ddr_xbank_pkg::*;
	logic rdCmd, wrCmd, rfCmd;
	logic [3:0] initCnt;
	logic [3:0] next_initCnt;

	////////////////////////////////////////////////////////////////////
	assign rdCmd = !csN && rasN && !casN && weN;
	assign wrCmd = !csN && rasN && !casN && !weN;
	assign rfCmd = !csN && !rasN && !casN && weN;
	// cycles since reset release, saturating
	always_comb begin
		next_initCnt = initCnt;
		if (initCnt != 4'hf)
			next_initCnt = initCnt + 4'h1;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			initCnt <= 4'h0;
		else
			initCnt <= next_initCnt;
	end

	////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_cke_held: assert property ($past(cke) |-> cke)
		else $error("clock enable dropped");
	a_init_quiet: assert property (!csN |-> initCnt > 4'(SRX_CK + 1))
		else $error("command before exit delay");
	a_cmd_single: assert property (!csN |=> csN)
		else $error("command held beyond one cycle");
	a_read_data: assert property (rdCmd |-> ##3 dqDevOe [*2])
		else $error("read data not on bus after latency");
	a_data_cause: assert property ($rose(dqDevOe) |-> $past(rdCmd, 3))
		else $error("read data without read command");
	a_write_data: assert property (
		wrCmd |=> (dqCtlOe && !writeDataMask) [*2])
		else $error("write beats missing");
	a_no_clash: assert property (!(dqCtlOe && dqDevOe))
		else $error("data bus driven by both ends");
	a_rd_to_wr: assert property (rdCmd |=> !wrCmd [*4])
		else $error("write too soon after read");
	a_wr_to_rd: assert property (wrCmd |=> !rdCmd [*3])
		else $error("read too soon after write");
	a_refresh_hold: assert property (rfCmd |=> csN [*2])
		else $error("command during refresh");

	c_write_ap: cover property (wrCmd && autoPrecharge);
	c_read_ap: cover property (rdCmd && autoPrecharge);
	c_refresh: cover property (rfCmd);
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import ddr_xbank_pkg::*;
	logic clk, rst, reqValid, reqAutoPrecharge, reqTaken, reqRejected;
	logic readValid, writeStrobe, cmdIllegal;
	cmd_e reqCmd;
	logic [BANK_W-1:0] reqBank;
	logic [DATA_W-1:0] reqWord, readWord, devWord, writeWord;
	logic [BANKS-1:0] bankIdle;
	int failures = 0;
	int n_compared = 0;
	int cyc = 0;
	int nStrobe = 0;
	int nRead = 0;
	int nCmd = 0;
	int nIllegal = 0;

	////////////////////////////////////////////////////////////////////
	ddr_cmd_if bus ();
	ddr_xbank_ctl ddr_xbank_ctl_inst (.clk(clk), .rst(rst), .bus(bus.ctl),
		.reqValid(reqValid), .reqCmd(reqCmd), .reqBank(reqBank),
		.reqAutoPrecharge(reqAutoPrecharge), .reqWord(reqWord),
		.reqTaken(reqTaken), .reqRejected(reqRejected),
		.readWord(readWord), .readValid(readValid));
	ddr_bank_device ddr_bank_device_inst (.clk(clk), .rst(rst),
		.bus(bus.dev), .readWord(devWord), .writeWord(writeWord),
		.writeStrobe(writeStrobe), .bankIdle(bankIdle),
		.cmdIllegal(cmdIllegal));
	ddr_xbank_properties ddr_xbank_properties_inst (.clk(clk), .rst(rst),
		.cke(bus.cke), .csN(bus.csN), .rasN(bus.rasN), .casN(bus.casN),
		.weN(bus.weN), .autoPrecharge(bus.autoPrecharge), .bank(bus.bank),
		.dqCtl(bus.dqCtl), .dqCtlOe(bus.dqCtlOe),
		.writeDataMask(bus.writeDataMask), .dqDev(bus.dqDev),
		.dqDevOe(bus.dqDevOe));

	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// event counters and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (writeStrobe === 1'b1)
			nStrobe <= nStrobe + 1;
		if (readValid === 1'b1)
			nRead <= nRead + 1;
		if (bus.csN === 1'b0)
			nCmd <= nCmd + 1;
		if (cmdIllegal === 1'b1)
			nIllegal <= nIllegal + 1;
		if (cyc == 2000) begin
			failures++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// holds the request until taken, returns take cycle and refusal
	task automatic issue(input cmd_e c, input int b, input logic ap,
		input logic [DATA_W-1:0] w, output int t, output logic rej);
		@(posedge clk);
		reqValid <= 1'b1;
		reqCmd <= c;
		reqBank <= BANK_W'(b);
		reqAutoPrecharge <= ap;
		reqWord <= w;
		do begin
			@(posedge clk);
			#1;
		end while (reqTaken !== 1'b1);
		t = cyc;
		rej = reqRejected;
		@(posedge clk);
		reqValid <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic s_basic_rw();
		int t, s0, r0;
		logic r;
		s0 = nStrobe;
		r0 = nRead;
		issue(CMD_ACTIVE, 0, 1'b0, 16'h0, t, r);
		check(r, 32'h0);
		issue(CMD_WRITE, 0, 1'b0, 16'ha5a5, t, r);
		issue(CMD_READ, 0, 1'b0, 16'h0, t, r);
		repeat (8) @(posedge clk);
		check(nStrobe - s0, 32'h2);
		check(writeWord, 32'ha5a5);
		check(nRead - r0, 32'h2);
		check(readWord, 32'h3c3c);
	endtask

	task automatic s_ap_gaps();
		int t0, t1;
		logic r;
		issue(CMD_ACTIVE, 1, 1'b0, 16'h0, t0, r);
		issue(CMD_ACTIVE, 2, 1'b0, 16'h0, t0, r);
		issue(CMD_WRITE, 0, 1'b1, 16'h1234, t0, r);
		issue(CMD_READ, 1, 1'b0, 16'h0, t1, r);
		check(32'(t1 - t0), 32'h4);
		issue(CMD_READ, 1, 1'b1, 16'h0, t0, r);
		issue(CMD_WRITE, 2, 1'b0, 16'h5678, t1, r);
		check(32'(t1 - t0), 32'h5);
		check(r, 32'h0);
		repeat (8) @(posedge clk);
		check(bankIdle, 32'hb);
		check(nIllegal, 32'h0);
	endtask

	task automatic s_refused();
		int t, n;
		logic r;
		n = nCmd;
		issue(CMD_READ, 3, 1'b0, 16'h0, t, r);
		check(r, 32'h1);
		// no read burst is running, so a burst stop has no bank to go to
		issue(CMD_BURST_STOP, 3, 1'b0, 16'h0, t, r);
		check(r, 32'h1);
		issue(CMD_NOP, 3, 1'b0, 16'h0, t, r);
		check(r, 32'h0);
		repeat (2) @(posedge clk);
		check(nCmd - n, 32'h0);
	endtask

	task automatic s_all_idle();
		int t, n;
		logic r;
		issue(CMD_PRECHARGE, 2, 1'b0, 16'h0, t, r);
		repeat (4) @(posedge clk);
		check(bankIdle, 32'hf);
		n = nCmd;
		issue(CMD_REFRESH, 0, 1'b0, 16'h0, t, r);
		check(r, 32'h0);
		issue(CMD_MODE_SET, 0, 1'b0, 16'h0, t, r);
		check(r, 32'h0);
		repeat (2) @(posedge clk);
		check(nCmd - n, 32'h2);
		check(nIllegal, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		reqValid = 1'b0;
		reqCmd = CMD_NOP;
		reqBank = 2'h0;
		reqAutoPrecharge = 1'b0;
		reqWord = 16'h0;
		devWord = 16'h3c3c;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		s_basic_rw();
		s_ap_gaps();
		s_refused();
		s_all_idle();
		repeat (4) @(posedge clk);
		give_verdict();
	end
endmodule
